// File: shared/rst_seq_pkg.sv
// Purpose: Constants shared by the reset sequencer and its timer
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes:   Registers keep one aligned word each

package rst_seq_pkg;
	// Register map
	localparam int unsigned AV_AW     = 4;
	localparam logic [3:0]  OFS_CTRL  = 4'h0;
	localparam logic [3:0]  OFS_STAT  = 4'h4;
	localparam logic [3:0]  OFS_WDT   = 4'h8;

	// Control word fields
	localparam int unsigned CTRL_XTAL_BIT  = 0;
	localparam int unsigned CTRL_ARM_BIT   = 1;
	localparam int unsigned CTRL_UFLOW_BIT = 2;
	localparam logic        XTAL_RST       = 1'b1;

	// Status word fields
	localparam int unsigned STAT_CAUSE_LSB = 0;
	localparam int unsigned STAT_HALT_BIT  = 2;
	localparam int unsigned STAT_STAB_BIT  = 3;
	localparam int unsigned STAT_RAM_BIT   = 4;
	localparam int unsigned STAT_ACC_BIT   = 5;
	localparam int unsigned STAT_RST_BIT   = 6;

	// Timer word fields
	localparam int unsigned WDT_PSC_LSB = 0;
	localparam int unsigned WDT_CNT_LSB = 8;

	// Last reset source
	localparam logic [1:0] CAUSE_POR = 2'h0;
	localparam logic [1:0] CAUSE_EXT = 2'h1;
	localparam logic [1:0] CAUSE_WD  = 2'h2;
	localparam logic [1:0] CAUSE_BO  = 2'h3;

	// Timing
	localparam int unsigned TC_DIV   = 10;
	localparam int unsigned STAB_TC  = 256;
	localparam int unsigned WD_W     = 8;
	localparam logic [7:0]  WD_LOAD  = 8'hff;
endpackage

// File: shared/wd_timer_if.sv
// Purpose: Link between sequencer and watchdog stabilisation timer
// Assumes: One clock domain
// Notes:   Sequencer drives control, timer returns its state

`timescale 1ns/10ps

interface wd_timer_if #(parameter int unsigned W = 8);
	logic         tick;
	logic         load;
	logic         run;
	logic [W-1:0] psc;
	logic [W-1:0] cnt;
	logic         done;

	modport ctl (output tick, load, run, input psc, cnt, done);
	modport tmr (input tick, load, run, output psc, cnt, done);
endinterface

// File: design/wd_stab_timer.sv
// Purpose: Watchdog prescaler and counter used as start-up delay
// Assumes: tick is one clock wide, once per instruction cycle
// Notes:   done rises when the prescaler first wraps while running

`timescale 1ns/10ps

module wd_stab_timer (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Sequencer side
	wd_timer_if.tmr  t
);
	import rst_seq_pkg::*;

	logic [WD_W-1:0] psc_q;
	logic [WD_W-1:0] cnt_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			psc_q <= WD_LOAD;
			cnt_q <= WD_LOAD;
		end else if (t.load) begin
			psc_q <= WD_LOAD;
			cnt_q <= WD_LOAD;
		end else if (t.run && t.tick) begin
			if (psc_q == '0) begin
				psc_q <= WD_LOAD;
				cnt_q <= cnt_q - 1'b1;
			end else begin
				psc_q <= psc_q - 1'b1;
			end
		end
	end

	assign t.psc  = psc_q;
	assign t.cnt  = cnt_q;
	// Counter leaving its load value ends the delay
	assign t.done = t.run && (cnt_q != WD_LOAD);
endmodule

// File: design/mcu_reset_sequencer.sv
// Purpose: Reset sequencer combining pin, watchdog and brown-out resets
// Assumes: clk is the oscillator; inputs synchronous except ext_rst_n
// Notes:   Register slave is Avalon-MM with one wait state
//
// Behaviour
// - Pin reset low forces reset at once, without a clock edge.
// - Pin release is synchronised; execution resumes on the third clock edge.
// - Pin or power-on reset: ports high-Z, output port ones, PC zero.
// - Pin reset keeps RAM and pointers; power-on reset leaves them undefined.
// - Any reset clears status, control, watchdog, wake and port registers; code keeps crystal bit except at power-on, arm bit at watchdog reset.
// - Any reset loads watchdog prescaler and counter with all ones.
// - Pin reset during halt ends halt and resets the device.
// - Halt left by pin: crystal loses timer and accumulator, others keep.
// - Crystal: pin-change wakeup from halt waits 256 instruction cycles.
// - Pin reset during brown-out acts only once supply recovers.
// - Watchdog timeout resets the device and leaves watchdog enabled; code acts on it only in ST_RUN, not in halt.
// - Watchdog reset keeps arm bit unchanged and sets underflow flag.
// - Watchdog reset resets ports, PC, control; keeps pointers.
// - Brown-out holds reset until the detector reports recovery.
// - Crystal: brown-out release waits 256 instruction cycles; else none.
// - Pin reset cancels a brown-out stabilisation delay in progress.
// - Brown-out reset wins over watchdog reset.
// - Brown-out loses RAM and pointers; from halt also timer, accumulator.
// - Instruction cycle is the oscillator divided by ten.
// - Delay timed by eight-bit prescaler feeding eight-bit counter.
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.

`timescale 1ns/10ps

module mcu_reset_sequencer #(
	parameter int unsigned TC_DIV_P = rst_seq_pkg::TC_DIV
) (
	// Clock and power-on reset
	input  wire logic                          clk,
	input  wire logic                          nrst,
	// Reset sources
	input  wire logic                          ext_rst_n,
	input  wire logic                          brown_out,
	input  wire logic                          wd_timeout,
	// Halt and wakeup
	input  wire logic                          halt_req,
	input  wire logic                          pin_change_wakeup,
	input  wire logic                          halt_restart_pin,
	// Avalon-MM slave
	input  wire logic [rst_seq_pkg::AV_AW-1:0] avs_address,
	input  wire logic                          avs_read,
	input  wire logic                          avs_write,
	input  wire logic [3:0]                    avs_byteenable,
	input  wire logic [31:0]                   avs_writedata,
	output logic [31:0]                        avs_readdata,
	output logic                               avs_waitrequest,
	// Core control
	output logic                               core_reset,
	output logic                               core_clk_en,
	output logic                               halted,
	output logic                               ram_retained,
	output logic                               acc_timer_kept,
	output logic                               wd_armed,
	output logic                               instruction_cycle
);
	import rst_seq_pkg::*;

	typedef enum logic [1:0] {ST_HOLD, ST_STAB, ST_RUN, ST_HALT} state_t;

	localparam int unsigned DW = $clog2(TC_DIV_P);

	if (TC_DIV_P < 2) begin : g_div_chk
		$error("TC_DIV_P must be at least 2");
	end

	// Pin reset path
	logic rst_all_n;
	logic ext_s1_q;
	logic ext_s2_q;
	logic ext_held;

	// Instruction cycle divider
	logic [DW-1:0] div_q;
	logic          tick_q;

	// Sequencer state
	state_t     state_q;
	state_t     state_d;
	logic [1:0] cause_q;
	logic [1:0] cause_d;
	logic       stab_pend_q;
	logic       stab_pend_d;
	logic       core_reset_q;
	logic       core_clk_en_q;
	logic       halted_q;
	logic       ram_kept_q;
	logic       acc_kept_q;
	logic       reset_now;

	// Software-visible control
	logic xtal_q;
	logic arm_q;
	logic arm_lock_q;
	logic uflow_q;
	logic wd_fire;

	// Bus slave
	logic        waitreq_q;
	logic [31:0] rdata_q;
	logic        bus_we;
	logic        ctrl_we;

	// Assertion helper
	logic [8:0] stab_ticks_q;

	wd_timer_if #(.W(WD_W)) wdt ();

	wd_stab_timer u_timer (
		.clk  (clk),
		.nrst (nrst),
		.t    (wdt.tmr)
	);

	// Pin low forces core reset with no clock
	assign rst_all_n = nrst & ext_rst_n;

	// Pin low clears the stages; power-on reset alone sets them, so
	// leaving power-on reset is not mistaken for a pin reset
	always_ff @(posedge clk or negedge ext_rst_n or negedge nrst) begin
		if (!ext_rst_n) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
		end else if (!nrst) begin
			ext_s1_q <= 1'b1;
			ext_s2_q <= 1'b1;
		end else begin
			ext_s1_q <= 1'b1;
			ext_s2_q <= ext_s1_q;
		end
	end

	assign ext_held = !ext_s2_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else if (div_q == DW'(TC_DIV_P - 1)) begin
			div_q  <= '0;
			tick_q <= 1'b1;
		end else begin
			div_q  <= div_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	assign wdt.tick = tick_q;
	assign wdt.load = (state_q == ST_HOLD) || (state_q == ST_HALT);
	assign wdt.run  = (state_q == ST_STAB);

	assign wd_fire   = wd_timeout && arm_q && (state_q == ST_RUN);
	assign reset_now = brown_out || ext_held || wd_fire;

	always_comb begin
		state_d     = state_q;
		cause_d     = cause_q;
		stab_pend_d = stab_pend_q;
		if (brown_out) begin
			// Supply low beats both other sources
			state_d     = ST_HOLD;
			cause_d     = CAUSE_BO;
			stab_pend_d = xtal_q;
		end else if (ext_held) begin
			state_d     = ST_HOLD;
			cause_d     = CAUSE_EXT;
			stab_pend_d = 1'b0;
		end else if (wd_fire) begin
			state_d     = ST_HOLD;
			cause_d     = CAUSE_WD;
			stab_pend_d = 1'b0;
		end else begin
			case (state_q)
				ST_HOLD: begin
					state_d = stab_pend_q ? ST_STAB : ST_RUN;
				end
				ST_STAB: begin
					if (wdt.done) begin
						state_d     = ST_RUN;
						stab_pend_d = 1'b0;
					end
				end
				ST_RUN: begin
					if (halt_req) begin
						state_d = ST_HALT;
					end
				end
				ST_HALT: begin
					if (pin_change_wakeup) begin
						state_d = xtal_q ? ST_STAB : ST_RUN;
					end else if (halt_restart_pin && !xtal_q) begin
						state_d = ST_RUN;
					end
				end
				default: begin
					state_d = ST_HOLD;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q     <= ST_HOLD;
			cause_q     <= CAUSE_POR;
			stab_pend_q <= 1'b0;
		end else begin
			state_q     <= state_d;
			cause_q     <= cause_d;
			stab_pend_q <= stab_pend_d;
		end
	end

	// Held reset tri-states ports, drives the output port high,
	// zeroes PC and clears the core's control and port registers
	always_ff @(posedge clk or negedge rst_all_n) begin
		if (!rst_all_n) begin
			core_reset_q <= 1'b1;
		end else begin
			core_reset_q <= (state_d == ST_HOLD) ||
				((state_d == ST_STAB) && stab_pend_d);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			core_clk_en_q <= 1'b0;
			halted_q      <= 1'b0;
		end else begin
			core_clk_en_q <= (state_d == ST_RUN);
			halted_q      <= (state_d == ST_HALT);
		end
	end

	// RAM, pointer and stack validity after the last reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ram_kept_q <= 1'b0;
		end else if (brown_out) begin
			ram_kept_q <= 1'b0;
		end else if (ext_held || wd_fire) begin
			ram_kept_q <= 1'b1;
		end
	end

	// Accumulator and timer validity, judged on entry to reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			acc_kept_q <= 1'b0;
		end else if (reset_now && (state_q != ST_HOLD)) begin
			acc_kept_q <= !((state_q == ST_HALT) &&
				(brown_out || xtal_q));
		end
	end

	assign bus_we  = avs_write && !waitreq_q;
	assign ctrl_we = bus_we && (avs_address == OFS_CTRL) &&
		avs_byteenable[0];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			xtal_q <= XTAL_RST;
		end else if (ctrl_we) begin
			xtal_q <= avs_writedata[CTRL_XTAL_BIT];
		end
	end

	// Arm bit is write-once between power-on, pin or brown-out resets
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			arm_q      <= 1'b0;
			arm_lock_q <= 1'b0;
		end else if (brown_out || ext_held) begin
			arm_q      <= 1'b0;
			arm_lock_q <= 1'b0;
		end else if (ctrl_we && !arm_lock_q) begin
			arm_q      <= avs_writedata[CTRL_ARM_BIT];
			arm_lock_q <= 1'b1;
		end
	end

	// Underflow flag: timeout sets, write one clears, set wins
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			uflow_q <= 1'b0;
		end else if (brown_out || ext_held) begin
			uflow_q <= 1'b0;
		end else if (wd_fire) begin
			uflow_q <= 1'b1;
		end else if (ctrl_we && avs_writedata[CTRL_UFLOW_BIT]) begin
			uflow_q <= 1'b0;
		end
	end

	// One wait state: request seen, answered next edge
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			waitreq_q <= 1'b1;
		end else if (waitreq_q && (avs_read || avs_write)) begin
			waitreq_q <= 1'b0;
		end else begin
			waitreq_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= '0;
		end else if (waitreq_q && avs_read) begin
			rdata_q <= '0;
			case (avs_address)
				OFS_CTRL: begin
					rdata_q[CTRL_XTAL_BIT]  <= xtal_q;
					rdata_q[CTRL_ARM_BIT]   <= arm_q;
					rdata_q[CTRL_UFLOW_BIT] <= uflow_q;
				end
				OFS_STAT: begin
					rdata_q[STAT_CAUSE_LSB +: 2] <= cause_q;
					rdata_q[STAT_HALT_BIT] <= (state_q == ST_HALT);
					rdata_q[STAT_STAB_BIT] <= (state_q == ST_STAB);
					rdata_q[STAT_RAM_BIT]  <= ram_kept_q;
					rdata_q[STAT_ACC_BIT]  <= acc_kept_q;
					rdata_q[STAT_RST_BIT]  <= core_reset_q;
				end
				OFS_WDT: begin
					rdata_q[WDT_PSC_LSB +: WD_W] <= wdt.psc;
					rdata_q[WDT_CNT_LSB +: WD_W] <= wdt.cnt;
				end
				default: begin
					rdata_q <= '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stab_ticks_q <= '0;
		end else if (state_q != ST_STAB) begin
			stab_ticks_q <= '0;
		end else if (tick_q) begin
			stab_ticks_q <= stab_ticks_q + 1'b1;
		end
	end

	assign avs_readdata      = rdata_q;
	assign avs_waitrequest   = waitreq_q;
	assign core_reset        = core_reset_q;
	assign core_clk_en       = core_clk_en_q;
	assign halted            = halted_q;
	assign ram_retained      = ram_kept_q;
	assign acc_timer_kept    = acc_kept_q;
	assign wd_armed          = arm_q;
	assign instruction_cycle = tick_q;

	pin_hold_a: assert property (
		@(posedge clk) disable iff (!nrst)
		!ext_rst_n |-> core_reset_q)
		else $error("pin reset low but core not in reset");

	pin_release_a: assert property (
		@(posedge clk) disable iff (!nrst)
		$rose(ext_rst_n) ##0 (ext_rst_n && !brown_out)[*5]
		|-> !core_reset_q)
		else $error("core still in reset after pin release");

	bo_hold_a: assert property (
		@(posedge clk) disable iff (!nrst)
		brown_out |=> core_reset_q && (state_q == ST_HOLD))
		else $error("brown-out did not hold reset");

	stab_len_a: assert property (
		@(posedge clk) disable iff (!nrst)
		(state_q == ST_STAB) && wdt.done |-> stab_ticks_q == 9'd256)
		else $error("stabilisation delay not 256 cycles");

	stab_cancel_a: assert property (
		@(posedge clk) disable iff (!nrst)
		(state_q == ST_STAB) && ext_held && !brown_out
		|=> !stab_pend_q ##1 (state_q == ST_RUN) || ext_held)
		else $error("pin reset did not cancel delay");

	bo_prio_a: assert property (
		@(posedge clk) disable iff (!nrst)
		brown_out && (wd_fire || ext_held) |=> cause_q == CAUSE_BO)
		else $error("brown-out lost priority");

	wd_keep_a: assert property (
		@(posedge clk) disable iff (!nrst)
		wd_fire && !brown_out && !ext_held
		|=> arm_q == $past(arm_q) && uflow_q && cause_q == CAUSE_WD)
		else $error("watchdog reset changed arm bit");

	halt_exit_a: assert property (
		@(posedge clk) disable iff (!nrst)
		(state_q == ST_HALT) && ext_held |=> (state_q == ST_HOLD))
		else $error("pin reset did not end halt");

	wake_stab_a: assert property (
		@(posedge clk) disable iff (!nrst)
		(state_q == ST_HALT) && pin_change_wakeup && xtal_q &&
		!brown_out && !ext_held |=> (state_q == ST_STAB) && !core_reset_q)
		else $error("crystal wakeup skipped delay");

	wd_load_a: assert property (
		@(posedge clk) disable iff (!nrst)
		(state_q == ST_HOLD) |=> wdt.psc == WD_LOAD && wdt.cnt == WD_LOAD)
		else $error("watchdog not loaded with ones");

	ram_keep_a: assert property (
		@(posedge clk) disable iff (!nrst)
		ext_held && !brown_out |=> ram_kept_q)
		else $error("pin reset lost RAM validity");

	halt_acc_a: assert property (
		@(posedge clk) disable iff (!nrst)
		(state_q == ST_HALT) && ext_held && !brown_out
		|=> acc_kept_q == !$past(xtal_q))
		else $error("accumulator validity wrong after halt exit");
endmodule

// File: bench/rst_partner.sv
// Purpose: Outside reset circuit and supply monitor for the sequencer
// Assumes: Bench asks for pin reset and brown-out through request levels
// Notes:   Pin stays low a minimum time so the oscillator can restart

`timescale 1ns/10ps

module rst_partner #(
	parameter int unsigned MIN_LOW = 4
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Bench requests
	input  wire logic pin_req,
	input  wire logic bo_req,
	// Device pins
	output logic      ext_rst_n,
	output logic      brown_out
);
	logic [7:0] low_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ext_rst_n <= 1'b1;
			low_q     <= 8'h00;
		end else if (pin_req) begin
			ext_rst_n <= 1'b0;
			low_q     <= 8'h00;
		end else if (low_q < 8'(MIN_LOW)) begin
			low_q <= low_q + 8'h01;
		end else begin
			ext_rst_n <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			brown_out <= 1'b0;
		end else begin
			brown_out <= bo_req;
		end
	end
endmodule

// File: bench/test_mcu_reset_sequencer.sv
// Purpose: Self-checking bench for the reset sequencer
// Assumes: Bus answers are taken at the rising edge with waitrequest low
// Notes:   Long delays run at full length, 256 instruction cycles

`timescale 1ns/10ps

`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
	miscompares++; $display("[FAIL] %s expected %h seen %h", nm, ex, gt); \
	end end

module test_mcu_reset_sequencer;
	import rst_seq_pkg::*;
	logic clk, nrst, ext_rst_n, brown_out, wd_timeout, halt_req;
	logic pin_change_wakeup, halt_restart_pin, pin_req, bo_req;
	logic [AV_AW-1:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic core_reset, core_clk_en, halted, ram_retained;
	logic acc_timer_kept, wd_armed, instruction_cycle;
	int miscompares, n_compared, cyc, n;

	mcu_reset_sequencer dut_u (.clk(clk), .nrst(nrst), .ext_rst_n(ext_rst_n),
		.brown_out(brown_out), .wd_timeout(wd_timeout), .halt_req(halt_req),
		.pin_change_wakeup(pin_change_wakeup),
		.halt_restart_pin(halt_restart_pin), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.core_reset(core_reset), .core_clk_en(core_clk_en), .halted(halted),
		.ram_retained(ram_retained), .acc_timer_kept(acc_timer_kept),
		.wd_armed(wd_armed), .instruction_cycle(instruction_cycle));

	rst_partner part_u (.clk(clk), .nrst(nrst), .pin_req(pin_req),
		.bo_req(bo_req), .ext_rst_n(ext_rst_n), .brown_out(brown_out));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("Compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			miscompares++;
			report_and_stop();
		end
	end

	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d, input logic [3:0] be);
		int k;
		k = 0;
		@(posedge clk);
		avs_address    <= a;
		avs_writedata  <= d;
		avs_byteenable <= be;
		avs_write      <= wr;
		avs_read       <= ~wr;
		do begin
			@(posedge clk);
			k++;
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		`CHK("bus waits", 2, k)
	endtask

	// Waits for core_reset (0), core_clk_en (1), halted (2) or
	// instruction_cycle (3) to reach v
	task automatic wait_sel(input int sel, input logic v, input int mx);
		logic s;
		n = 0;
		do begin
			@(negedge clk);
			n++;
			s = (sel == 0) ? core_reset : (sel == 1) ? core_clk_en :
				(sel == 2) ? halted : instruction_cycle;
		end while (s !== v && n < mx);
	endtask

	task automatic pulse(input int sel);
		@(posedge clk);
		if (sel == 0) wd_timeout <= 1'b1;
		if (sel == 1) halt_req <= 1'b1;
		if (sel == 2) pin_change_wakeup <= 1'b1;
		if (sel == 3) halt_restart_pin <= 1'b1;
		@(posedge clk);
		{wd_timeout, halt_req, pin_change_wakeup, halt_restart_pin} <= 4'h0;
	endtask

	task automatic pin_reset();
		@(posedge clk);
		pin_req <= 1'b1;
		@(posedge clk);
		pin_req <= 1'b0;
		@(negedge clk);
		`CHK("pin async", 1'b1, core_reset)
		wait (ext_rst_n === 1'b1);
		wait_sel(0, 1'b0, 20);
		`CHK("pin release", 4, n)
	endtask

	task automatic cause(input logic [1:0] c);
		bus(1'b0, OFS_STAT, 32'h0, 4'hf);
		`CHK("cause", c, rd[STAT_CAUSE_LSB +: 2])
	endtask

	initial begin
		{nrst, wd_timeout, halt_req, pin_change_wakeup} = 4'h0;
		{halt_restart_pin, pin_req, bo_req, avs_read, avs_write} = 5'h0;
		avs_address = 4'h0;
		avs_byteenable = 4'h0;
		avs_writedata = 32'h0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		// Reset values and refusals
		bus(1'b0, OFS_CTRL, 32'h0, 4'hf);
		`CHK("ctrl reset", 32'h1, rd)
		cause(CAUSE_POR);
		`CHK("por ram lost", 1'b0, ram_retained)
		bus(1'b0, 4'hc, 32'h0, 4'hf);
		`CHK("unmapped", 32'h0, rd)
		wait_sel(0, 1'b0, 5);
		@(negedge instruction_cycle);
		wait_sel(3, 1'b1, 40);
		`CHK("tc period", TC_DIV, n)
		$display("Test reset values done");
		// Watchdog
		pulse(0);
		@(negedge clk);
		`CHK("wd unarmed", 1'b0, core_reset)
		bus(1'b1, OFS_CTRL, 32'h2, 4'he);
		@(negedge clk);
		`CHK("be refused", 1'b0, wd_armed)
		bus(1'b1, OFS_CTRL, 32'h3, 4'hf);
		@(negedge clk);
		`CHK("armed", 1'b1, wd_armed)
		pulse(0);
		@(negedge clk);
		`CHK("wd reset", 1'b1, core_reset)
		@(negedge clk);
		`CHK("wd release", 1'b0, core_reset)
		`CHK("wd keeps ram", 1'b1, ram_retained)
		`CHK("wd stays on", 1'b1, wd_armed)
		bus(1'b0, OFS_CTRL, 32'h0, 4'hf);
		`CHK("wd arm kept", 32'h7, rd)
		cause(CAUSE_WD);
		bus(1'b1, OFS_CTRL, 32'h5, 4'hf);
		bus(1'b0, OFS_CTRL, 32'h0, 4'hf);
		`CHK("write once", 32'h3, rd)
		$display("Test watchdog done");
		// Brown-out with watchdog together, crystal delay
		@(posedge clk);
		bo_req <= 1'b1;
		@(posedge clk);
		wd_timeout <= 1'b1;
		@(posedge clk);
		wd_timeout <= 1'b0;
		@(negedge clk);
		`CHK("bo reset", 1'b1, core_reset)
		repeat (20) @(posedge clk);
		`CHK("bo holds", 1'b1, core_reset)
		cause(CAUSE_BO);
		bus(1'b0, OFS_WDT, 32'h0, 4'hf);
		`CHK("wd loaded", 16'hffff, rd[15:0])
		bo_req <= 1'b0;
		repeat (200) @(posedge clk);
		bus(1'b0, OFS_STAT, 32'h0, 4'hf);
		`CHK("stab run", 1'b1, rd[STAT_STAB_BIT])
		bus(1'b0, OFS_WDT, 32'h0, 4'hf);
		`CHK("cnt at load", WD_LOAD, rd[WDT_CNT_LSB +: 8])
		repeat (2300) @(posedge clk);
		`CHK("stab length", 1'b1, core_reset)
		wait_sel(0, 1'b0, 200);
		`CHK("stab end", 1'b1, n < 120)
		`CHK("bo ram lost", 1'b0, ram_retained)
		$display("Test brown-out done");
		// Pin reset while supply low, then pin cancels a delay
		pin_reset();
		cause(CAUSE_EXT);
		`CHK("pin ram kept", 1'b1, ram_retained)
		bo_req <= 1'b1;
		pin_req <= 1'b1;
		repeat (6) @(posedge clk);
		cause(CAUSE_BO);
		bo_req <= 1'b0;
		repeat (4) @(posedge clk);
		cause(CAUSE_EXT);
		`CHK("pin holds", 1'b1, core_reset)
		pin_req <= 1'b0;
		wait (ext_rst_n === 1'b1);
		wait_sel(0, 1'b0, 20);
		`CHK("pin after bo", 4, n)
		@(posedge clk);
		bo_req <= 1'b1;
		repeat (4) @(posedge clk);
		bo_req <= 1'b0;
		repeat (100) @(posedge clk);
		pin_reset();
		$display("Test pin reset done");
		// Halt exits without crystal
		bus(1'b1, OFS_CTRL, 32'h0, 4'hf);
		bo_req <= 1'b1;
		repeat (4) @(posedge clk);
		bo_req <= 1'b0;
		wait (brown_out === 1'b0);
		wait_sel(0, 1'b0, 5);
		`CHK("no delay", 2, n)
		pulse(1);
		wait_sel(2, 1'b1, 5);
		`CHK("halted", 1'b1, halted)
		pulse(3);
		wait_sel(2, 1'b0, 3);
		`CHK("restart", 1'b1, core_clk_en)
		pulse(1);
		wait_sel(2, 1'b1, 5);
		pin_reset();
		`CHK("halt ended", 1'b0, halted)
		`CHK("rc acc kept", 1'b1, acc_timer_kept)
		// Halt exits with crystal
		bus(1'b1, OFS_CTRL, 32'h1, 4'hf);
		pulse(1);
		wait_sel(2, 1'b1, 5);
		pin_reset();
		`CHK("xtal acc lost", 1'b0, acc_timer_kept)
		`CHK("xtal ram kept", 1'b1, ram_retained)
		pulse(1);
		wait_sel(2, 1'b1, 5);
		pulse(2);
		repeat (2400) @(posedge clk);
		`CHK("wake wait", 1'b0, core_clk_en)
		`CHK("wake no rst", 1'b0, core_reset)
		wait_sel(1, 1'b1, 300);
		`CHK("wake end", 1'b1, core_clk_en)
		$display("Test halt done");
		report_and_stop();
	end
endmodule
